// >>> dv/sfd_link_props.sv
`timescale 1ns/1ps
module sfd_link_props
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe,
    input wire logic chip_en,
    input wire logic monitor_output
);
    ////////////////////////////////////////////////////////////////////
    // helper: serial clock rises seen since the last load strobe
    logic sclk_q_ff; // serial clock one cycle back
    logic [4:0] rise_cnt_ff; // bits shifted into the current word
    // edge count, cleared by the load so each word counts alone
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sclk_q_ff <= 1'b0;
            rise_cnt_ff <= 5'h00;
        end
        else
        begin
            sclk_q_ff <= sclk;
            if (load_strobe)
                rise_cnt_ff <= 5'h00;
            else if (sclk && !sclk_q_ff)
                rise_cnt_ff <= rise_cnt_ff + 5'h01;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////
    // wire rules, checked between the two design ends
    reset_idle_a: assert property ($fell(rst_i) |-> !sclk && !sdata && !load_strobe)
        else $error("link lines not idle after reset");
    mon_idle_a: assert property ($fell(rst_i) |-> !monitor_output && !chip_en)
        else $error("enable or monitor not low after reset");
    word_length_a: assert property ($rose(load_strobe) |-> rise_cnt_ff == 5'h18)
        else $error("load strobe without a full word shifted");
    word_bound_a: assert property (rise_cnt_ff <= 5'h18)
        else $error("more serial clocks than one word");
    sclk_high_a: assert property ($rose(sclk) |=> sclk ##1 !sclk)
        else $error("serial clock high phase wrong length");
    sclk_low_a: assert property ($fell(sclk) |=> !sclk)
        else $error("serial clock low phase too short");
    data_hold_a: assert property (sclk |-> $stable(sdata))
        else $error("serial data moved while clock high");
    load_gap_a: assert property ($rose(load_strobe) |-> !$past(sclk) && !$past(sclk, 2))
        else $error("load strobe too close to last clock");
    load_width_a: assert property ($rose(load_strobe) |=> load_strobe ##1 !load_strobe)
        else $error("load strobe width wrong");
    load_quiet_a: assert property (load_strobe |-> !sclk)
        else $error("serial clock high during load");
endmodule : sfd_link_props

// >>> dv/tb_synth_feedback_divider_serial_load.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module tb_synth_feedback_divider_serial_load;
    import sfd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic rf_in_i = 1'b0; // slow stand-in for the RF input ahead of the prescaler
    logic ref_in_i = 1'b0;
    logic run = 1'b0; // input pins toggle only after reset
    logic [2:0] ph = 3'h0; // divides the clock for the pin patterns
    logic cp_drive_o, cp_oe_o, sw_one_o, sw_two_o, clamp_o, powered_o;
    logic [31:0] rv;
    int miscompares = 0;
    int total_checks = 0;
    int rf_cnt = 0;
    int ref_cnt = 0;
    sfd_link_if link();
    sfd_host i_sfd_host (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(link));
    sfd_dev i_sfd_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link), .rf_in_i(rf_in_i),
        .ref_in_i(ref_in_i), .cp_drive_o(cp_drive_o), .cp_oe_o(cp_oe_o),
        .ref_path_switch_one_o(sw_one_o), .ref_path_switch_two_o(sw_two_o),
        .ref_clamp_switch_o(clamp_o), .powered_o(powered_o));
    sfd_link_props i_sfd_link_props (.clk_i(clk_i), .rst_i(rst_i), .sclk(link.sclk),
        .sdata(link.sdata), .load_strobe(link.load_strobe), .chip_en(link.chip_en),
        .monitor_output(link.monitor_output));
    ////////////////////////////////////////////////////////////////////
    // clock and pin patterns; levels of 2 and 4 cycles suit the 2-flop samplers
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        ph <= ph + 3'h1;
        rf_in_i <= run & ph[1];
        ref_in_i <= run & ph[2];
    end
    always @(posedge rf_in_i) rf_cnt++;
    always @(posedge ref_in_i) ref_cnt++;
    ////////////////////////////////////////////////////////////////////
    // access tasks
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle
    // one word out, then poll busy; the device sees the load a few cycles late
    task automatic send(input logic [31:0] w);
        int i;
        wr(ADDR_WORD, w);
        for (i = 0; i < 200; i++)
        begin
            rd(ADDR_STAT, rv);
            if (rv[STAT_BUSY_BIT] === 1'b0)
                break;
        end
        if (i == 200)
        begin
            $display("mismatch busy poll expected 0 seen 1");
            miscompares++;
            stop_test();
        end
        settle(8);
    endtask : send
    // pin rises between the 2nd and 3rd monitor toggles; the first may be partial
    task automatic meas(input logic use_rf, input int ex, input string nm);
        int i;
        int n0;
        logic m;
        n0 = 0;
        for (int k = 0; k < 3; k++)
        begin
            m = link.monitor_output;
            // look just after the edge so the monitor and pin counts have settled
            for (i = 0; i < 2000 && link.monitor_output === m; i++)
                settle(1);
            if (i == 2000)
            begin
                $display("mismatch monitor toggle expected change seen none");
                miscompares++;
                stop_test();
            end
            if (k == 1)
                n0 = use_rf ? rf_cnt : ref_cnt;
        end
        `CHK(nm, ex, (use_rf ? rf_cnt : ref_cnt) - n0)
    endtask : meas
    task automatic power(input logic ex);
        settle(8);
        `CHK("powered", ex, powered_o)
        `CHK("clamp", ~ex, clamp_o)
        `CHK("ref switches", {ex, ex}, {sw_one_o, sw_two_o})
        if (!ex)
        begin
            `CHK("pump enable", 1'b0, cp_oe_o)
            `CHK("pump drive", 1'b0, cp_drive_o)
        end
    endtask : power
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        run <= 1'b1;
        power(1'b0);
        wr(ADDR_CTRL, 32'h1);
        rd(ADDR_CTRL, rv);
        `CHK("ctrl", 32'h00000001, rv)
        rd(4'hC, rv);
        `CHK("unmapped", 32'h00000000, rv)
        send(32'h00000008);
        send(32'h00000305);
        send(32'h00000032);
        power(1'b1);
        rd(ADDR_STAT, rv);
        `CHK("monitor high", 1'b1, rv[STAT_MON_BIT])
        send(32'h00000002);
        rd(ADDR_STAT, rv);
        `CHK("monitor low", 1'b0, rv[STAT_MON_BIT])
        // every modulus; the last goes through the initialization latch
        for (int p = 0; p < 4; p++)
        begin
            send((32'(p) << 22) | 32'h22 | ((p == 3) ? 32'h1 : 32'h0));
            meas(1'b1, 3 * (8 << p) + 1, "feedback ratio");
        end
        send(32'h00000042);
        meas(1'b0, 2, "reference ratio");
        // software power-down survives a chip enable cycle
        send(32'h0000000A);
        power(1'b0);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        power(1'b0);
        send(32'h00000002);
        power(1'b1);
        wr(ADDR_CTRL, 32'h0);
        power(1'b0);
        // too small a main count is refused; the serial port still runs
        send(32'h00000201);
        rd(ADDR_STAT, rv);
        `CHK("count error", 1'b1, rv[STAT_ERR_BIT])
        wr(ADDR_STAT, 32'h2);
        rd(ADDR_STAT, rv);
        `CHK("error cleared", 1'b0, rv[STAT_ERR_BIT])
        wr(ADDR_CTRL, 32'h1);
        power(1'b1);
        // 24 rf rises and 12 reference rises both last 96 cycles, so lock must show
        send(32'h00000030);
        send(32'h00000301);
        send(32'h00000012);
        settle(1000);
        rd(ADDR_STAT, rv);
        `CHK("monitor lock", 1'b1, rv[STAT_MON_BIT])
        stop_test();
    end
endmodule : tb_synth_feedback_divider_serial_load

// >>> rtl/sfd_dev.sv
// What this block does
// - shift serial bit in on clock rise
// - host sends MSB first, select bits last
// - load strobe rise copies word to latch
// - chip enable low: off, pump three-state
// - enable high powers up unless bit forbids
// - monitor shows lock, divided RF or reference
// - prescaler moduli 8, 16, 32, 64
// - ratio is main times modulus plus swallow
// - host keeps ratio above modulus squared minus; sfd_host only refuses a main count below 3
// - main counter 13 bits, values 3 up
// - swallow counter 6 bits, 0 to 63
// - host keeps counter rate within 300 MHz; sfd_host does not check it
// - power down opens path, closes clamp
// - select codes pick reference, counters, function, init
// - reference counter 14 bits, ratio 1 up
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module sfd_dev
    import sfd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    sfd_link_if.dev link,
    input wire logic rf_in_i,
    input wire logic ref_in_i,
    output logic cp_drive_o,
    output logic cp_oe_o,
    output logic ref_path_switch_one_o,
    output logic ref_path_switch_two_o,
    output logic ref_clamp_switch_o,
    output logic powered_o
);

    ////////////////////////////////////////////////////////////////////
    // state record
    typedef struct packed {
        logic [NSYNC-1:0] smp1;          // first sampler stage
        logic [NSYNC-1:0] smp2;          // second sampler stage
        logic [NSYNC-1:0] smp3;          // previous level for edges
        logic [WORD_W-1:0] shreg;        // serial input register
        logic [REF_W-1:0] ref_latch;     // reference ratio
        logic [SWAL_W-1:0] swal_latch;   // swallow count
        logic [MAIN_W-1:0] main_latch;   // main count
        logic [WORD_W-1:0] func;         // function word
        logic [PCNT_W-1:0] pre_cnt;      // rf edges left this prescaler cycle
        logic [SWAL_W-1:0] swal_cnt;     // extended cycles left
        logic [MAIN_W-1:0] main_cnt;     // prescaler cycles left
        logic [REF_W-1:0] ref_cnt;       // reference edges left
        logic fb_tgl;                    // divided rf square wave
        logic ref_tgl;                   // divided reference square wave
        logic up;                        // pump sourcing
        logic dn;                        // pump sinking
        logic [1:0] fb_seen;             // feedback ticks this reference period
        logic [2:0] lock_cnt;            // good periods in a row
        logic locked;                    // lock detect
        logic pwr;                       // powered up
        logic mon;                       // monitor pin
    } sfd_dev_st_t;

    sfd_dev_st_t q_ff;   // registered state
    sfd_dev_st_t nxt_q;  // next state

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        logic [NSYNC-1:0] rise;
        logic [PCNT_W-1:0] pmod;
        logic [SWAL_W-1:0] swal_n;
        logic pre_tick;
        logic fb_tick;
        logic ref_tick;
        logic init_load;
        logic hold;
        logic want_off;
        rise = '0;
        pmod = '0;
        swal_n = '0;
        pre_tick = 1'b0;
        fb_tick = 1'b0;
        ref_tick = 1'b0;
        init_load = 1'b0;
        hold = 1'b0;
        want_off = 1'b0;
        nxt_q = q_ff;

        // pins cross into this clock through two stages; the first is
        // only ever copied, edges come from stages two and three
        nxt_q.smp1 = {ref_in_i, rf_in_i, link.chip_en, link.load_strobe,
                      link.sdata, link.sclk};
        nxt_q.smp2 = q_ff.smp1;
        nxt_q.smp3 = q_ff.smp2;
        rise = q_ff.smp2 & ~q_ff.smp3;

        if (rise[IX_SCLK])
        begin
            nxt_q.shreg = {q_ff.shreg[WORD_W-2:0], q_ff.smp2[IX_DATA]};
        end

        if (rise[IX_LOAD])
        begin
            unique case (q_ff.shreg[SEL_LSB +: 2])
                SEL_REF:  nxt_q.ref_latch = q_ff.shreg[REF_LSB +: REF_W];
                SEL_CNT:
                begin
                    nxt_q.main_latch = q_ff.shreg[MAIN_LSB +: MAIN_W];
                    nxt_q.swal_latch = q_ff.shreg[SWAL_LSB +: SWAL_W];
                end
                SEL_FUNC: nxt_q.func = q_ff.shreg;
                SEL_INIT:
                begin
                    // init also restarts the counters from their loads
                    nxt_q.func = q_ff.shreg;
                    init_load = 1'b1;
                end
            endcase
        end

        pmod = PCNT_W'(PRE_BASE << q_ff.func[PRE_LSB +: 2]);

        if (rise[IX_REF])
        begin
            if (q_ff.ref_cnt <= REF_W'(1))
            begin
                // ratio zero behaves as one
                ref_tick = 1'b1;
                nxt_q.ref_cnt = q_ff.ref_latch;
            end
            else
            begin
                nxt_q.ref_cnt = q_ff.ref_cnt - REF_W'(1);
            end
        end

        // ratio main times modulus plus swallow
        if (rise[IX_RF])
        begin
            if (q_ff.pre_cnt <= PCNT_ONE)
            begin
                pre_tick = 1'b1;
            end
            else
            begin
                nxt_q.pre_cnt = q_ff.pre_cnt - PCNT_ONE;
            end
        end
        if (pre_tick)
        begin
            if (q_ff.main_cnt <= MAIN_W'(1))
            begin
                fb_tick = 1'b1;
                nxt_q.main_cnt = q_ff.main_latch;
                swal_n = q_ff.swal_latch;
            end
            else
            begin
                nxt_q.main_cnt = q_ff.main_cnt - MAIN_W'(1);
                swal_n = (q_ff.swal_cnt != '0) ? q_ff.swal_cnt - SWAL_W'(1) : '0;
            end
            nxt_q.swal_cnt = swal_n;
            // extended cycle while swallows remain
            nxt_q.pre_cnt = (swal_n != '0) ? pmod + PCNT_ONE : pmod;
        end

        nxt_q.fb_tgl = q_ff.fb_tgl ^ fb_tick;
        nxt_q.ref_tgl = q_ff.ref_tgl ^ ref_tick;

        // phase detector: the leading edge starts the pump, the lagging
        // edge ends it
        if ((q_ff.up | ref_tick) & (q_ff.dn | fb_tick))
        begin
            nxt_q.up = 1'b0;
            nxt_q.dn = 1'b0;
        end
        else
        begin
            nxt_q.up = q_ff.up | ref_tick;
            nxt_q.dn = q_ff.dn | fb_tick;
        end

        // frequency lock: exactly one feedback tick per reference period;
        // coarse, it does not measure phase error
        if (ref_tick)
        begin
            if ((q_ff.fb_seen + 2'(fb_tick)) == 2'h1)
            begin
                if (q_ff.lock_cnt != LOCK_COUNT)
                begin
                    nxt_q.lock_cnt = q_ff.lock_cnt + 3'h1;
                end
                nxt_q.locked = (q_ff.lock_cnt + 3'h1) >= LOCK_COUNT;
            end
            else
            begin
                nxt_q.lock_cnt = '0;
                nxt_q.locked = 1'b0;
            end
            nxt_q.fb_seen = '0;
        end
        else if (fb_tick && q_ff.fb_seen != 2'h3)
        begin
            nxt_q.fb_seen = q_ff.fb_seen + 2'h1;
        end

        want_off = q_ff.func[PD_CTRL_BIT];
        if (!q_ff.smp2[IX_CE])
        begin
            nxt_q.pwr = 1'b0;
        end
        else if (!want_off)
        begin
            nxt_q.pwr = 1'b1;
        end
        else if (!q_ff.func[PD_SYNC_BIT] || ref_tick || fb_tick)
        begin
            // synchronous mode waits for a pump event to avoid a jump
            nxt_q.pwr = 1'b0;
        end

        // powered down or counter reset: counters sit at their loads,
        // the serial register keeps working
        hold = !q_ff.pwr || q_ff.func[RST_BIT] || init_load;
        if (hold)
        begin
            nxt_q.ref_cnt = q_ff.ref_latch;
            nxt_q.main_cnt = q_ff.main_latch;
            nxt_q.swal_cnt = q_ff.swal_latch;
            nxt_q.pre_cnt = (q_ff.swal_latch != '0) ? pmod + PCNT_ONE : pmod;
            nxt_q.up = 1'b0;
            nxt_q.dn = 1'b0;
            nxt_q.fb_seen = '0;
            nxt_q.lock_cnt = '0;
            nxt_q.locked = 1'b0;
        end

        unique case (q_ff.func[MON_LSB +: 3])
            MON_LOCK: nxt_q.mon = q_ff.locked;
            MON_FB:   nxt_q.mon = q_ff.fb_tgl;
            MON_HIGH: nxt_q.mon = 1'b1;
            MON_REF:  nxt_q.mon = q_ff.ref_tgl;
            default:  nxt_q.mon = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q_ff <= '0;
            q_ff.func <= FUNC_RST;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign link.monitor_output = q_ff.mon;
    assign cp_drive_o = q_ff.up;
    assign cp_oe_o = q_ff.pwr & (q_ff.up ^ q_ff.dn);
    assign ref_path_switch_one_o = q_ff.pwr;
    assign ref_path_switch_two_o = q_ff.pwr;
    assign ref_clamp_switch_o = ~q_ff.pwr;
    assign powered_o = q_ff.pwr;

endmodule : sfd_dev

// >>> rtl/sfd_host.sv
`timescale 1ns/1ps
module sfd_host
    import sfd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    sfd_link_if.host link
);

    ////////////////////////////////////////////////////////////////////
    // state record
    typedef enum logic [2:0] {
        H_IDLE = 3'h0,   // waiting for a word
        H_LOW = 3'h1,    // clock low, data set up
        H_HIGH = 3'h2,   // clock high, device samples
        H_GAP = 3'h3,    // clock to strobe setup
        H_LOAD = 3'h4    // strobe high
    } sfd_hst_t;

    typedef struct packed {
        sfd_hst_t state;
        logic [3:0] tick;            // cycles into phase
        logic [4:0] bit_cnt;         // bits still to send after this one
        logic [WORD_W-1:0] shreg;    // word being sent
        logic ce;                    // chip enable drive
        logic err;                   // refused word, sticky
        logic sclk;
        logic sdata;
        logic load;
        logic mon1;                  // monitor sampler stage one
        logic mon2;                  // monitor sampler stage two
        logic [31:0] rdata;
    } sfd_host_st_t;

    sfd_host_st_t q_ff;   // registered state
    sfd_host_st_t nxt_q;  // next state

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        logic phase_end;
        logic [MAIN_W-1:0] main_val;
        phase_end = (q_ff.tick == HALF_LAST);
        main_val = wdata_i[MAIN_LSB +: MAIN_W];
        nxt_q = q_ff;
        nxt_q.mon1 = link.monitor_output;
        nxt_q.mon2 = q_ff.mon1;
        nxt_q.tick = phase_end ? 4'h0 : q_ff.tick + 4'h1;

        // register writes
        if (wr_i)
        begin
            if (addr_i == ADDR_CTRL)
            begin
                nxt_q.ce = wdata_i[CTRL_CE_BIT];
            end
            else if (addr_i == ADDR_STAT && wdata_i[STAT_ERR_BIT])
            begin
                // write one clears; a refusal only arises on a word write
                nxt_q.err = 1'b0;
            end
            else if (addr_i == ADDR_WORD && q_ff.state == H_IDLE)
            begin
                if (wdata_i[SEL_LSB +: 2] == SEL_CNT && main_val < MAIN_MIN)
                begin
                    nxt_q.err = 1'b1;
                end
                else
                begin
                    nxt_q.shreg = wdata_i[WORD_W-1:0];
                    nxt_q.bit_cnt = LAST_BIT;
                    nxt_q.sdata = wdata_i[WORD_W-1];
                    nxt_q.sclk = 1'b0;
                    nxt_q.tick = 4'h0;
                    nxt_q.state = H_LOW;
                end
            end
        end

        // serial sequencer; a word write while busy is dropped
        unique case (q_ff.state)
            H_IDLE:
            begin
                nxt_q.load = 1'b0;
            end
            H_LOW:
            begin
                if (phase_end)
                begin
                    nxt_q.sclk = 1'b1;
                    nxt_q.state = H_HIGH;
                end
            end
            H_HIGH:
            begin
                if (phase_end)
                begin
                    nxt_q.sclk = 1'b0;
                    if (q_ff.bit_cnt == 5'h00)
                    begin
                        nxt_q.state = H_GAP;
                    end
                    else
                    begin
                        nxt_q.bit_cnt = q_ff.bit_cnt - 5'h01;
                        nxt_q.shreg = {q_ff.shreg[WORD_W-2:0], 1'b0};
                        nxt_q.sdata = q_ff.shreg[WORD_W-2];
                        nxt_q.state = H_LOW;
                    end
                end
            end
            H_GAP:
            begin
                if (phase_end)
                begin
                    nxt_q.load = 1'b1;
                    nxt_q.state = H_LOAD;
                end
            end
            H_LOAD:
            begin
                if (phase_end)
                begin
                    nxt_q.load = 1'b0;
                    nxt_q.state = H_IDLE;
                end
            end
            default:
            begin
                nxt_q.state = H_IDLE;
            end
        endcase

        // read data stand one cycle after the strobe, unmapped reads zero
        nxt_q.rdata = '0;
        if (rd_i)
        begin
            if (addr_i == ADDR_CTRL)
            begin
                nxt_q.rdata[CTRL_CE_BIT] = q_ff.ce;
            end
            else if (addr_i == ADDR_STAT)
            begin
                nxt_q.rdata[STAT_BUSY_BIT] = (q_ff.state != H_IDLE);
                nxt_q.rdata[STAT_ERR_BIT] = q_ff.err;
                nxt_q.rdata[STAT_MON_BIT] = q_ff.mon2;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q_ff <= '0;
            q_ff.state <= H_IDLE;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign link.sclk = q_ff.sclk;
    assign link.sdata = q_ff.sdata;
    assign link.load_strobe = q_ff.load;
    assign link.chip_en = q_ff.ce;
    assign rdata_o = q_ff.rdata;

endmodule : sfd_host

// >>> shared/sfd_link_if.sv
`timescale 1ns/1ps
interface sfd_link_if;
    logic sclk;             // serial clock
    logic sdata;            // serial data
    logic load_strobe;      // latch transfer on rising edge
    logic chip_en;          // chip enable, high runs
    logic monitor_output;   // selected internal signal
    modport dev (input sclk, input sdata, input load_strobe, input chip_en,
                 output monitor_output);
    modport host (output sclk, output sdata, output load_strobe, output chip_en,
                  input monitor_output);
endinterface : sfd_link_if

// >>> shared/sfd_pkg.sv
package sfd_pkg;
    ////////////////////////////////////////////////////////////////////
    // serial word layout
    localparam int WORD_W = 24;                 // shift register length
    localparam logic [1:0] SEL_REF = 2'h0;      // reference counter latch
    localparam logic [1:0] SEL_CNT = 2'h1;      // main and swallow counters
    localparam logic [1:0] SEL_FUNC = 2'h2;     // function latch
    localparam logic [1:0] SEL_INIT = 2'h3;     // initialization latch
    localparam int SEL_LSB = 0;                 // latch select field
    localparam int REF_LSB = 2;                 // reference ratio field
    localparam int REF_W = 14;
    localparam int SWAL_LSB = 2;                // swallow count field
    localparam int SWAL_W = 6;
    localparam int MAIN_LSB = 8;                // main count field
    localparam int MAIN_W = 13;
    localparam int PRE_LSB = 22;                // prescaler select field
    localparam int RST_BIT = 2;                 // counter reset bit
    localparam int PD_CTRL_BIT = 3;             // powerdown_control_bit
    localparam int MON_LSB = 4;                 // monitor select field
    localparam int PD_SYNC_BIT = 21;            // power down waits for pump event
    localparam logic [WORD_W-1:0] FUNC_RST = 24'h000000;
    localparam logic [MAIN_W-1:0] MAIN_MIN = 13'h0003;
    ////////////////////////////////////////////////////////////////////
    // prescaler and monitor
    localparam int PCNT_W = 7;                  // holds 65
    localparam logic [PCNT_W-1:0] PRE_BASE = 7'h08;
    localparam logic [PCNT_W-1:0] PCNT_ONE = 7'h01;
    localparam logic [2:0] MON_LOW = 3'h0;
    localparam logic [2:0] MON_LOCK = 3'h1;
    localparam logic [2:0] MON_FB = 3'h2;
    localparam logic [2:0] MON_HIGH = 3'h3;
    localparam logic [2:0] MON_REF = 3'h4;
    localparam logic [2:0] LOCK_COUNT = 3'h3;   // good reference periods to lock
    ////////////////////////////////////////////////////////////////////
    // device pin sampler lanes
    localparam int NSYNC = 6;
    localparam int IX_SCLK = 0;
    localparam int IX_DATA = 1;
    localparam int IX_LOAD = 2;
    localparam int IX_CE = 3;
    localparam int IX_RF = 4;
    localparam int IX_REF = 5;
    ////////////////////////////////////////////////////////////////////
    // host timing and register port
    localparam int CLK_PERIOD_NS = 50;
    localparam int SCLK_HALF_NS = 100;          // each serial phase, least time
    localparam int HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
    localparam logic [3:0] ADDR_WORD = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    localparam int CTRL_CE_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    localparam int STAT_MON_BIT = 2;
    localparam logic [4:0] LAST_BIT = 5'h17;
endpackage : sfd_pkg
